// ---- inc/dui_pkg.sv ----
// constants for the two-channel uart host port (i2c or spi slave)
// assumes a single 100 MHz clock domain; bus pins arrive asynchronously
`default_nettype none
package dui_pkg;
  // synchroniser lanes
  localparam int SY_W = 5;
  localparam int F_SCL = 0;
  localparam int F_SDA = 1;
  localparam int F_PIN0 = 2;
  localparam int F_PIN1 = 3;
  localparam int F_SEL = 4;
  localparam logic [SY_W-1:0] SY_RST = 5'h1F;
  // bus rates and timing
  localparam int CLK_MHZ = 100;
  localparam int I2C_STD_KBPS = 100;
  localparam int I2C_FAST_KBPS = 400;
  localparam int FAST_BIT_CYC = (CLK_MHZ * 1000) / I2C_FAST_KBPS;
  localparam int SYNC_LAT_CYC = 4;
  // slave address: fixed upper nibble, three strap bits
  localparam logic [3:0] ADDR_BASE = 4'h6;
  // sub-address / spi header fields
  localparam int HDR_RW = 7;
  localparam int REG_HI = 6;
  localparam int REG_LO = 3;
  localparam int CH_HI = 2;
  localparam int CH_LO = 1;
  localparam logic [3:0] REG_TX_HOLD = 4'h0;
  localparam logic [1:0] CH_A = 2'h0;
  localparam logic [1:0] CH_B = 2'h1;
  // uart fifo depth
  localparam logic [6:0] FIFO_DEPTH = 7'h40;
  // bit counter
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BYTE_DONE = 4'h8;
  typedef enum logic [3:0] {
    I_IDLE = 4'h0,
    I_ADDR = 4'h1,
    I_ADDR_ACK = 4'h2,
    I_SUB = 4'h3,
    I_SUB_ACK = 4'h4,
    I_WR = 4'h5,
    I_WR_ACK = 4'h6,
    I_RD = 4'h7,
    I_RD_ACK = 4'h8
  } dui_i2c_st_t;
endpackage : dui_pkg
`default_nettype wire

// ---- hw/dui_host_port.sv ----
// host serial front end: i2c slave or spi slave onto uart register port
// assumes uart register file on i_mclk answers reads in the same cycle
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - select pin high i2c, low spi
// - spi chip select low-active, else ignore clocking
// - spi serial input on address-one pin
// - address pins pick i2c slave address
// - standard and fast mode rates supported
// - start: sda falls with scl high
// - first byte: 7-bit address plus direction
// - second byte latched as target register
// - acknowledge each written byte except reserved-channel data, sda low
// - full tx fifo write: nack, discard
// - stop: sda rises with scl high
// - two channels, 64-byte fifos each
// - eight addresses 0110xxx by strap wiring
// - address bit 0 high read, low write
// - register bits 6:3, channel bits 2:1
module dui_host_port (
  // clock, reset, enable
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_ce,
  // bus pins
  input wire logic i_sel_i2c,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe_n,
  input wire logic i_addr_low_or_chip_select_n,
  input wire logic i_addr_high_or_serial_in,
  output logic o_so,
  output logic o_so_oe_n,
  // uart register port
  output logic o_wr,
  output logic o_rd,
  output logic [3:0] o_reg_addr,
  output logic o_reg_chan,
  output logic [7:0] o_wr_data,
  input wire logic [7:0] i_rd_data,
  input wire logic [6:0] i_tx_level_a,
  input wire logic [6:0] i_tx_level_b
);
  logic [dui_pkg::SY_W-1:0] sy1, sy2, sy3, f, next_f;
  logic q_scl, q_sda, next_q_scl, next_q_sda;
  logic [1:0] st_hi, st_st, next_st_hi, next_st_st;
  logic st_lo, next_st_lo;
  logic i2c, scl_rise, scl_fall, start, stop;
  logic [6:0] my_addr;
  logic [1:0] a0_code;

  // header byte target is legal and, for the tx holding register, not full
  function automatic logic chan_ok(input logic [7:0] h);
    chan_ok = (h[dui_pkg::CH_HI:dui_pkg::CH_LO] == dui_pkg::CH_A)
      || (h[dui_pkg::CH_HI:dui_pkg::CH_LO] == dui_pkg::CH_B);
  endfunction : chan_ok

  function automatic logic tx_full(input logic [7:0] h, input logic [6:0] la,
      input logic [6:0] lb);
    tx_full = (h[dui_pkg::REG_HI:dui_pkg::REG_LO] == dui_pkg::REG_TX_HOLD)
      && ((h[dui_pkg::CH_LO] ? lb : la) == dui_pkg::FIFO_DEPTH);
  endfunction : tx_full

  // filtered level moves only once second and third stage agree
  always_comb begin
    next_f = (sy2 & ~(sy2 ^ sy3)) | (f & (sy2 ^ sy3));
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      sy1 <= dui_pkg::SY_RST;
      sy2 <= dui_pkg::SY_RST;
      sy3 <= dui_pkg::SY_RST;
      f <= dui_pkg::SY_RST;
    end else if (i_ce) begin
      sy1 <= {i_sel_i2c, i_addr_high_or_serial_in, i_addr_low_or_chip_select_n, i_sda, i_scl};
      sy2 <= sy1;
      sy3 <= sy2;
      f <= next_f;
    end
  end

  // a fast-mode bit spans far more cycles than the sync latency
  assign i2c = f[dui_pkg::F_SEL];
  assign scl_rise = f[dui_pkg::F_SCL] & ~q_scl;
  assign scl_fall = ~f[dui_pkg::F_SCL] & q_scl;
  assign start = q_sda & ~f[dui_pkg::F_SDA] & q_scl & f[dui_pkg::F_SCL];
  assign stop = ~q_sda & f[dui_pkg::F_SDA] & q_scl & f[dui_pkg::F_SCL];

  // strap decode: a pin tied to scl or sda is told apart by when it is low
  assign a0_code = !st_hi[0] ? 2'h1 : !st_st[0] ? 2'h3 : !st_lo ? 2'h2 : 2'h0;
  assign my_addr = {dui_pkg::ADDR_BASE, (!st_hi[1] || !st_st[1]), a0_code};

  always_comb begin
    next_q_scl = f[dui_pkg::F_SCL];
    next_q_sda = f[dui_pkg::F_SDA];
    next_st_hi = st_hi;
    next_st_st = st_st;
    next_st_lo = st_lo;
    if (f[dui_pkg::F_SCL] && f[dui_pkg::F_SDA]) begin
      next_st_hi = f[dui_pkg::F_PIN1:dui_pkg::F_PIN0];
    end
    if (start) begin
      next_st_st = f[dui_pkg::F_PIN1:dui_pkg::F_PIN0];
    end
    if (!f[dui_pkg::F_SCL]) begin
      next_st_lo = f[dui_pkg::F_PIN0];
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      q_scl <= 1'b1;
      q_sda <= 1'b1;
      st_hi <= 2'h3;
      st_st <= 2'h3;
      st_lo <= 1'b1;
    end else if (i_ce) begin
      q_scl <= next_q_scl;
      q_sda <= next_q_sda;
      st_hi <= next_st_hi;
      st_st <= next_st_st;
      st_lo <= next_st_lo;
    end
  end

  // i2c slave
  dui_pkg::dui_i2c_st_t ist, next_ist;
  logic [3:0] icnt, next_icnt;
  logic [7:0] ish, next_ish, isub, next_isub, iwd, next_iwd;
  logic irw, next_irw, idrv, next_idrv, iwr, next_iwr, ird, next_ird;

  always_comb begin
    next_ist = ist;
    next_icnt = icnt;
    next_ish = ish;
    next_isub = isub;
    next_iwd = iwd;
    next_irw = irw;
    next_idrv = idrv;
    next_iwr = 1'b0;
    next_ird = 1'b0;
    if (!i2c) begin
      next_ist = dui_pkg::I_IDLE;
      next_idrv = 1'b0;
    end else if (start) begin
      next_ist = dui_pkg::I_ADDR;
      next_icnt = 4'h0;
      next_idrv = 1'b0;
    end else if (stop) begin
      next_ist = dui_pkg::I_IDLE;
      next_idrv = 1'b0;
    end else if (scl_rise) begin
      unique case (ist)
        dui_pkg::I_ADDR, dui_pkg::I_SUB, dui_pkg::I_WR: begin
          next_ish = {ish[6:0], f[dui_pkg::F_SDA]};
          next_icnt = icnt + 4'h1;
        end
        // master nack ends the read burst
        dui_pkg::I_RD_ACK: if (f[dui_pkg::F_SDA]) next_ist = dui_pkg::I_IDLE;
        default: ;
      endcase
    end else if (scl_fall) begin
      unique case (ist)
        dui_pkg::I_ADDR: if (icnt == dui_pkg::BYTE_DONE) begin
          if (ish[7:1] == my_addr) begin
            next_irw = ish[0];
            next_idrv = 1'b1;
            next_ist = dui_pkg::I_ADDR_ACK;
          end else begin
            next_ist = dui_pkg::I_IDLE;
          end
        end
        dui_pkg::I_SUB: if (icnt == dui_pkg::BYTE_DONE) begin
          next_isub = ish;
          next_idrv = 1'b1;
          next_ist = dui_pkg::I_SUB_ACK;
        end
        dui_pkg::I_WR: if (icnt == dui_pkg::BYTE_DONE) begin
          next_iwd = ish;
          next_iwr = chan_ok(isub) && !tx_full(isub, i_tx_level_a, i_tx_level_b);
          next_idrv = next_iwr;
          next_ist = dui_pkg::I_WR_ACK;
        end
        dui_pkg::I_SUB_ACK, dui_pkg::I_WR_ACK: begin
          next_idrv = 1'b0;
          next_icnt = 4'h0;
          next_ist = dui_pkg::I_WR;
        end
        dui_pkg::I_ADDR_ACK, dui_pkg::I_RD_ACK: begin
          next_icnt = 4'h0;
          next_idrv = 1'b0;
          next_ist = dui_pkg::I_SUB;
          if (irw || ist == dui_pkg::I_RD_ACK) begin
            next_ird = chan_ok(isub);
            next_ish = chan_ok(isub) ? i_rd_data : 8'h00;
            next_idrv = !next_ish[7];
            next_icnt = 4'h1;
            next_ist = dui_pkg::I_RD;
          end
        end
        dui_pkg::I_RD: begin
          if (icnt == dui_pkg::BYTE_DONE) begin
            next_idrv = 1'b0;
            next_ist = dui_pkg::I_RD_ACK;
          end else begin
            next_ish = {ish[6:0], 1'b0};
            next_idrv = !ish[6];
            next_icnt = icnt + 4'h1;
          end
        end
        default: next_ist = dui_pkg::I_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      ist <= dui_pkg::I_IDLE;
      icnt <= 4'h0;
      ish <= 8'h00;
      isub <= 8'h00;
      iwd <= 8'h00;
      irw <= 1'b0;
      idrv <= 1'b0;
      iwr <= 1'b0;
      ird <= 1'b0;
    end else if (i_ce) begin
      ist <= next_ist;
      icnt <= next_icnt;
      ish <= next_ish;
      isub <= next_isub;
      iwd <= next_iwd;
      irw <= next_irw;
      idrv <= next_idrv;
      iwr <= next_iwr;
      ird <= next_ird;
    end
  end

  // spi slave, mode 0: master idles clock low between frames
  logic [3:0] scnt, next_scnt;
  logic [7:0] ssh, next_ssh, shdr, next_shdr, sout, next_sout, swd, next_swd;
  logic shav, next_shav, sso, next_sso, swr, next_swr, srd, next_srd;
  logic [7:0] sbyte;

  assign sbyte = {ssh[6:0], f[dui_pkg::F_PIN1]};

  always_comb begin
    next_scnt = scnt;
    next_ssh = ssh;
    next_shdr = shdr;
    next_sout = sout;
    next_swd = swd;
    next_shav = shav;
    next_sso = sso;
    next_swr = 1'b0;
    next_srd = 1'b0;
    if (i2c || f[dui_pkg::F_PIN0]) begin
      next_scnt = 4'h0;
      next_shav = 1'b0;
      next_sso = 1'b0;
    end else if (scl_rise) begin
      next_ssh = sbyte;
      next_scnt = (scnt == dui_pkg::BIT_LAST) ? 4'h0 : scnt + 4'h1;
      if (scnt == dui_pkg::BIT_LAST) begin
        if (!shav) begin
          next_shdr = sbyte;
          next_shav = 1'b1;
        end
        if (shav ? shdr[dui_pkg::HDR_RW] : sbyte[dui_pkg::HDR_RW]) begin
          next_srd = chan_ok(shav ? shdr : sbyte);
          next_sout = next_srd ? i_rd_data : 8'h00;
        end else if (shav) begin
          next_swd = sbyte;
          // no acknowledge slot on spi: a full fifo simply drops the byte
          next_swr = chan_ok(shdr) && !tx_full(shdr, i_tx_level_a, i_tx_level_b);
        end
      end
    end else if (scl_fall) begin
      next_sso = sout[7];
      next_sout = {sout[6:0], 1'b0};
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      scnt <= 4'h0;
      ssh <= 8'h00;
      shdr <= 8'h00;
      sout <= 8'h00;
      swd <= 8'h00;
      shav <= 1'b0;
      sso <= 1'b0;
      swr <= 1'b0;
      srd <= 1'b0;
    end else if (i_ce) begin
      scnt <= next_scnt;
      ssh <= next_ssh;
      shdr <= next_shdr;
      sout <= next_sout;
      swd <= next_swd;
      shav <= next_shav;
      sso <= next_sso;
      swr <= next_swr;
      srd <= next_srd;
    end
  end

  // outputs
  assign o_sda = 1'b0;
  assign o_sda_oe_n = !(i2c && idrv);
  assign o_so = sso;
  assign o_so_oe_n = i2c || f[dui_pkg::F_PIN0];
  assign o_wr = iwr || swr;
  assign o_rd = ird || srd;
  assign o_reg_addr = i2c ? isub[dui_pkg::REG_HI:dui_pkg::REG_LO]
                          : shdr[dui_pkg::REG_HI:dui_pkg::REG_LO];
  assign o_reg_chan = i2c ? isub[dui_pkg::CH_LO] : shdr[dui_pkg::CH_LO];
  assign o_wr_data = i2c ? iwd : swd;

  property p_spi_i2c_idle;
    @(posedge i_mclk) disable iff (i_reset) (!i2c && i_ce) |=> ist == dui_pkg::I_IDLE;
  endproperty
  a_spi_i2c_idle: assert property (p_spi_i2c_idle) else $error("i2c active in spi mode");

  property p_cs_idle;
    @(posedge i_mclk) disable iff (i_reset)
      (!i2c && f[dui_pkg::F_PIN0] && i_ce) |=> (scnt == 4'h0 && !shav && !o_so);
  endproperty
  a_cs_idle: assert property (p_cs_idle) else $error("spi moved without select");

  property p_start;
    @(posedge i_mclk) disable iff (i_reset)
      (i2c && start && i_ce) |=> (ist == dui_pkg::I_ADDR && icnt == 4'h0);
  endproperty
  a_start: assert property (p_start) else $error("start not taken");

  property p_stop;
    @(posedge i_mclk) disable iff (i_reset)
      (i2c && stop && i_ce) |=> (ist == dui_pkg::I_IDLE && o_sda_oe_n);
  endproperty
  a_stop: assert property (p_stop) else $error("stop not taken");

  property p_sub_ack;
    @(posedge i_mclk) disable iff (i_reset) (ist == dui_pkg::I_SUB_ACK) |-> !o_sda_oe_n;
  endproperty
  a_sub_ack: assert property (p_sub_ack) else $error("sub-address not acked");

  property p_full_nack;
    @(posedge i_mclk) disable iff (i_reset)
      (i2c && i_ce && scl_fall && ist == dui_pkg::I_WR && icnt == dui_pkg::BYTE_DONE
        && tx_full(isub, i_tx_level_a, i_tx_level_b))
      |=> (ist == dui_pkg::I_WR_ACK && o_sda_oe_n && !o_wr);
  endproperty
  a_full_nack: assert property (p_full_nack) else $error("full fifo write acked");

  property p_resv_chan;
    @(posedge i_mclk) disable iff (i_reset) (i2c && (o_wr || o_rd)) |-> !isub[dui_pkg::CH_HI];
  endproperty
  a_resv_chan: assert property (p_resv_chan) else $error("reserved channel accessed");

  property p_read_dir;
    @(posedge i_mclk) disable iff (i_reset)
      (i2c && i_ce && scl_fall && ist == dui_pkg::I_ADDR_ACK && irw && !start && !stop)
      |=> (ist == dui_pkg::I_RD && icnt == 4'h1);
  endproperty
  a_read_dir: assert property (p_read_dir) else $error("read direction ignored");

  property p_addr_miss;
    @(posedge i_mclk) disable iff (i_reset)
      (i2c && i_ce && scl_fall && ist == dui_pkg::I_ADDR && icnt == dui_pkg::BYTE_DONE
        && ish[7:1] != my_addr) |=> (ist == dui_pkg::I_IDLE && o_sda_oe_n);
  endproperty
  a_addr_miss: assert property (p_addr_miss) else $error("foreign address acked");
endmodule : dui_host_port
`default_nettype wire

// ---- testbench/dui_master_model.sv ----
// i2c / spi bus master model for the host port bench
// assumes the bench resolves sda and so; half period is set by the bench
`timescale 1ns/100ps
`default_nettype none
module dui_master_model (
  // resolved lines
  input wire logic i_sda,
  input wire logic i_so,
  // master drives
  output logic o_scl,
  output logic o_sda_rel,
  output logic o_cs_n,
  output logic o_si
);
  int half_ns = 1250;
  logic r;
  initial begin
    o_scl = 1'b1;
    o_sda_rel = 1'b1;
    o_cs_n = 1'b1;
    o_si = 1'b0;
  end
  task set_idle(input logic lvl);
    o_scl = lvl;
    #(half_ns);
  endtask : set_idle
  // data moves mid low phase; line read at the end of the high phase
  task bit_io(input logic b, output logic q);
    #(half_ns / 2) o_sda_rel = b;
    #(half_ns / 2) o_scl = 1'b1;
    #(half_ns) q = i_sda;
    o_scl = 1'b0;
  endtask : bit_io
  task i2c_start;
    o_sda_rel = 1'b1;
    #(half_ns / 2) o_scl = 1'b1;
    #(half_ns / 2) o_sda_rel = 1'b0;
    #(half_ns / 2) o_scl = 1'b0;
  endtask : i2c_start
  task i2c_stop;
    #(half_ns / 2) o_sda_rel = 1'b0;
    #(half_ns / 2) o_scl = 1'b1;
    #(half_ns / 2) o_sda_rel = 1'b1;
    #(half_ns);
  endtask : i2c_stop
  task i2c_write(input logic [7:0] b, output logic ack_n);
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, ack_n);
  endtask : i2c_write
  task i2c_read(input logic ack_n, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, b[i]);
    end
    bit_io(ack_n, r);
  endtask : i2c_read
  // mode 0: so is read just before the fall, since it moves after the fall
  task spi_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      o_si = tx[i];
      #(half_ns) o_scl = 1'b1;
      #(half_ns) rx[i] = i_so;
      o_scl = 1'b0;
    end
  endtask : spi_byte
  task spi_cs(input logic n);
    #(half_ns) o_cs_n = n;
    o_si = ~o_si;
    #(half_ns);
  endtask : spi_cs
endmodule : dui_master_model
`default_nettype wire

// ---- testbench/test_dui_host_port.sv ----
// self-checking bench for the host port: expected register strobes queued, a monitor pops
// assumes the master model owns bus timing; register file answered by rd_byte
`timescale 1ns/100ps
`default_nettype none
module test_dui_host_port;
  typedef struct packed {logic wr; logic [3:0] ra; logic ch; logic [7:0] d;} dui_ev_t;
  logic i_mclk = 1'b0;
  logic i_reset = 1'b1;
  logic ce = 1'b1;
  logic sel = 1'b1;
  logic [1:0] a0c = 2'h0;
  logic [1:0] a1c = 2'h0;
  logic [7:0] rd_byte = 8'h00;
  logic [6:0] lvl_a = 7'h00;
  logic [6:0] lvl_b = 7'h00;
  wire logic scl, sda_rel, cs_n, si, sda, so, pin0, pin1;
  wire logic sd_o, sd_oe_n, so_d, so_oe_n, wr, rd, rc;
  wire logic [3:0] ra;
  wire logic [7:0] wd;
  int mismatches = 0;
  int checks_done = 0;
  int seed = 57873;
  dui_ev_t exp_q[$];
  dui_ev_t ev;
  always #5 i_mclk = ~i_mclk;
  // strap codes: 0 supply, 1 ground, 2 clock line, 3 data line
  function automatic logic strap(input logic [1:0] c, input logic s_cl, input logic s_da);
    return (c == 2'h0) ? 1'b1 : (c == 2'h1) ? 1'b0 : (c == 2'h2) ? s_cl : s_da;
  endfunction : strap
  assign sda = sda_rel & (sd_oe_n | sd_o);
  assign so = so_oe_n ? ~so_d : so_d;
  assign pin0 = sel ? strap(a0c, scl, sda) : cs_n;
  assign pin1 = sel ? strap(a1c, scl, sda) : si;
  dui_host_port u_dut (.i_mclk(i_mclk), .i_reset(i_reset), .i_ce(ce), .i_sel_i2c(sel),
    .i_scl(scl), .i_sda(sda), .o_sda(sd_o), .o_sda_oe_n(sd_oe_n),
    .i_addr_low_or_chip_select_n(pin0), .i_addr_high_or_serial_in(pin1), .o_so(so_d),
    .o_so_oe_n(so_oe_n), .o_wr(wr), .o_rd(rd), .o_reg_addr(ra), .o_reg_chan(rc),
    .o_wr_data(wd), .i_rd_data(rd_byte), .i_tx_level_a(lvl_a), .i_tx_level_b(lvl_b));
  dui_master_model u_master (.i_sda(sda), .i_so(so), .o_scl(scl), .o_sda_rel(sda_rel),
    .o_cs_n(cs_n), .o_si(si));
  task automatic chk(input string nm, input logic [20:0] exp, input logic [20:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic push(input logic w, input logic [3:0] a, input logic c, input logic [7:0] d);
    exp_q.push_back({w, a, c, d});
  endtask : push
  task automatic i2c_wr(input logic [7:0] b, input logic exp_n, input string nm);
    logic a;
    u_master.i2c_write(b, a);
    chk(nm, {20'h0, exp_n}, {20'h0, a});
  endtask : i2c_wr
  task automatic sync(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask : sync
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish
  // monitor: every strobe must match the oldest note; falling edge keeps clear of the launch
  always @(negedge i_mclk) begin
    if (wr === 1'b1 || rd === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("stray strobe", 21'h0, {wr, rd, 19'h0});
      end else begin
        ev = exp_q.pop_front();
        chk("strobe", {ev.wr, ~ev.wr, 6'h0, ev.ra, ev.ch, ev.d},
          {wr, rd, 6'h0, ra, rc, wr ? wd : 8'h00});
      end
    end
  end
  initial begin
    repeat (95000) @(posedge i_mclk);
    mismatches++;
    $display("BAD watchdog expected done seen hang");
    tally_and_finish;
  end
  initial begin
    logic [6:0] adr;
    logic [7:0] b;
    logic [7:0] d;
    sync(10);
    i_reset = 1'b0;
    sync(20);
    chk("so_oe_n i2c", 21'h1, {20'h0, so_oe_n});
    for (int k = 0; k < 8; k++) begin
      a1c = {k[0], k[2]};
      a0c = k[1:0];
      adr = {4'h6, k[2], k[1:0]};
      sync(20);
      u_master.i2c_start();
      i2c_wr({adr, 1'b0}, 1'b0, "addr ack");
      u_master.i2c_stop();
      u_master.i2c_start();
      i2c_wr({adr ^ 7'h01, 1'b0}, 1'b1, "foreign addr");
      u_master.i2c_stop();
    end
    a1c = 2'h0;
    a0c = 2'h0;
    sync(20);
    // burst into channel b fifo; last byte meets a full fifo
    u_master.i2c_start();
    i2c_wr(8'h60, 1'b0, "addr");
    i2c_wr({1'b0, 4'h0, 2'h1, 1'b0}, 1'b0, "sub");
    for (int j = 0; j < 3; j++) begin
      d = 8'($random(seed));
      sync(1);
      lvl_b = (j == 2) ? 7'h40 : (7'($random(seed)) & 7'h3F);
      if (j < 2) push(1'b1, 4'h0, 1'b1, d);
      i2c_wr(d, j == 2, "data ack");
    end
    u_master.i2c_stop();
    // reserved channel write is refused
    u_master.i2c_start();
    i2c_wr(8'h60, 1'b0, "addr");
    u_master.i2c_write({1'b0, 4'h0, 2'h2, 1'b0}, b[0]);
    i2c_wr(8'h5A, 1'b1, "reserved write");
    u_master.i2c_stop();
    // read twice from reg 5 of channel a through a repeated start
    rd_byte = 8'($random(seed));
    u_master.i2c_start();
    i2c_wr(8'h60, 1'b0, "addr");
    i2c_wr({1'b0, 4'h5, 2'h0, 1'b0}, 1'b0, "sub");
    push(1'b0, 4'h5, 1'b0, 8'h00);
    push(1'b0, 4'h5, 1'b0, 8'h00);
    u_master.i2c_start();
    i2c_wr(8'h61, 1'b0, "addr read");
    u_master.i2c_read(1'b0, b);
    chk("i2c rd0", {13'h0, rd_byte}, {13'h0, b});
    u_master.i2c_read(1'b1, b);
    chk("i2c rd1", {13'h0, rd_byte}, {13'h0, b});
    u_master.i2c_stop();
    // spi: clock idles low, 80 ns link clock
    u_master.half_ns = 40;
    u_master.set_idle(1'b0);
    sync(1);
    sel = 1'b0;
    sync(20);
    chk("so_oe_n idle", 21'h1, {20'h0, so_oe_n});
    u_master.spi_cs(1'b0);
    sync(8);
    chk("so_oe_n sel", 21'h0, {20'h0, so_oe_n});
    d = 8'($random(seed));
    lvl_a = 7'($random(seed)) & 7'h3F;
    push(1'b1, 4'h0, 1'b0, d);
    u_master.spi_byte({1'b0, 4'h0, 2'h0, 1'b0}, b);
    u_master.spi_byte(d, b);
    sync(1);
    lvl_a = 7'h40;
    u_master.spi_byte(~d, b);
    u_master.spi_cs(1'b1);
    u_master.spi_byte({1'b0, 4'h1, 2'h0, 1'b0}, b);
    u_master.spi_byte(d, b);
    // spi read: each full byte of a channel a or b frame clocks another register read
    rd_byte = 8'($random(seed));
    push(1'b0, 4'h7, 1'b1, 8'h00);
    push(1'b0, 4'h7, 1'b1, 8'h00);
    u_master.spi_cs(1'b0);
    u_master.spi_byte({1'b1, 4'h7, 2'h1, 1'b0}, b);
    u_master.spi_byte(8'h00, b);
    chk("spi rd", {13'h0, rd_byte}, {13'h0, b});
    u_master.spi_cs(1'b1);
    u_master.spi_cs(1'b0);
    u_master.spi_byte({1'b1, 4'h7, 2'h3, 1'b0}, b);
    u_master.spi_byte(8'h00, b);
    chk("spi reserved rd", 21'h0, {13'h0, b});
    u_master.spi_cs(1'b1);
    // enable low freezes the port: a whole write frame must leave no strobe
    sync(1);
    ce = 1'b0;
    u_master.spi_cs(1'b0);
    chk("so_oe_n frozen", 21'h1, {20'h0, so_oe_n});
    u_master.spi_byte({1'b0, 4'h0, 2'h0, 1'b0}, b);
    u_master.spi_byte(d, b);
    u_master.spi_cs(1'b1);
    sync(4);
    ce = 1'b1;
    sync(10);
    for (int n = 0; n < 100 && exp_q.size() != 0; n++) @(posedge i_mclk);
    chk("pending strobes", 21'h0, 21'(exp_q.size()));
    tally_and_finish;
  end
endmodule : test_dui_host_port
`default_nettype wire
